/* File: dv/rsc_capture_chk.sv */
// Port assertions for the capture channel.
// Assumes one clock domain with a synchronous active-high reset.
`default_nettype none
////////////////////////////////////////
module rsc_capture_chk (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       pready,
    input wire logic       fifo_full,
    input wire logic       fifo_wr_valid,
    input wire logic       fifo_flush,
    input wire logic       luma_dma_event,
    input wire logic       channel_a_video_event,
    input wire logic [1:0] ten_bit_packing,
    input wire logic       stream_input_format
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    property p_ready;
        s_setup |=> s_access;
    endproperty
    a_ready: assert property (p_ready) else $error("late answer");
    property p_wr_gap;
        fifo_wr_valid |=> !fifo_wr_valid [*4];
    endproperty
    a_wr_gap: assert property (p_wr_gap)
        else $error("two writes for one edge");
    property p_full;
        fifo_wr_valid |-> !$past(fifo_full);
    endproperty
    a_full: assert property (p_full) else $error("write while full");
    property p_flush_evt;
        fifo_flush |-> (!luma_dma_event && !channel_a_video_event) [*8];
    endproperty
    a_flush_evt: assert property (p_flush_evt)
        else $error("event after flush");
    property p_flush_wr;
        fifo_flush |-> !fifo_wr_valid [*8];
    endproperty
    a_flush_wr: assert property (p_flush_wr)
        else $error("write while blocked");
    property p_yevt;
        luma_dma_event |-> !channel_a_video_event &&
            (fifo_wr_valid || $past(fifo_wr_valid) || $past(fifo_full));
    endproperty
    a_yevt: assert property (p_yevt) else $error("stray luma event");
    property p_aevt;
        channel_a_video_event |->
            fifo_wr_valid || $past(fifo_wr_valid) || $past(fifo_full);
    endproperty
    a_aevt: assert property (p_aevt) else $error("stray video event");
    property p_pack;
        $changed(ten_bit_packing) |-> $past(psel && penable && pwrite, 2);
    endproperty
    a_pack: assert property (p_pack) else $error("packing moved");
    property p_fmt;
        $changed(stream_input_format) |-> $past(psel && penable && pwrite, 2);
    endproperty
    a_fmt: assert property (p_fmt) else $error("format moved");
endmodule : rsc_capture_chk
bind rsc_capture rsc_capture_chk u_rsc_capture_chk (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
    .fifo_full(fifo_full), .fifo_wr_valid(fifo_wr_valid),
    .fifo_flush(fifo_flush), .luma_dma_event(luma_dma_event),
    .channel_a_video_event(channel_a_video_event),
    .ten_bit_packing(ten_bit_packing),
    .stream_input_format(stream_input_format));
`default_nettype wire

/* File: dv/rsc_src_model.sv */
// Behavioural source of the capture link: clock, qualifier, strobe, data.
// Assumes the bench calls send; the link clock rests low between bursts.
`default_nettype none
////////////////////////////////////////
module rsc_src_model (
    // Link pins.
    output var logic        lclk,
    output var logic        qual,
    output var logic        pstart,
    output var logic        perr,
    output var logic [19:0] data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [19:0] seq = 20'h0;
    initial begin
        lclk = 1'b0;
        qual = 1'b0;
        pstart = 1'b0;
        perr = 1'b0;
        data = 20'h0;
    end
    // Sends n edges; released pins show the inverse of the last data.
    task automatic send(input int n, input logic q, input logic st);
        #13;
        for (int i = 0; i < n; i++) begin
            qual = q;
            pstart = st && (i == 0);
            data = seq;
            #160 lclk = 1'b1;
            seq = seq + 20'h1;
            #160 lclk = 1'b0;
        end
        qual = 1'b0;
        pstart = 1'b0;
        data = ~data;
    endtask : send
endmodule : rsc_src_model
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench: APB register access plus raw and stream capture.
// Assumes the design, its bound checker and the source model.
`default_nettype none
`include "rsc_defines.svh"
////////////////////////////////////////
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, full = 1'b0;
    logic        gen = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rv, c0;
    logic        pready, pslverr, lclk, qual, pst, perr, re;
    logic        wr, flush, yev, aev, irq, fmt;
    logic [19:0] cdata, wdata, last_d;
    logic [1:0]  pack;
    int          n_fail = 0, check_count = 0, n_wr, n_y, n_a, n_fl;
    always #20 clk = ~clk;
    rsc_capture u_rsc_capture (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .channel_input_clock(lclk), .capture_qualifier(qual),
        .packet_start_strobe(pst), .packet_error(perr),
        .capture_data(cdata), .global_capture_enable(gen),
        .fifo_full(full), .fifo_wr_valid(wr), .fifo_wr_data(wdata),
        .fifo_flush(flush), .luma_dma_event(yev),
        .channel_a_video_event(aev), .irq(irq), .ten_bit_packing(pack),
        .stream_input_format(fmt));
    rsc_src_model u_rsc_src_model (.lclk(lclk), .qual(qual), .pstart(pst),
        .perr(perr), .data(cdata));
    always @(posedge clk) begin
        if (wr) begin
            n_wr++;
            last_d = wdata;
        end
        n_y += int'(yev);
        n_a += int'(aev);
        n_fl += int'(flush);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rv, exp);
    endtask : rd
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask : settle
    task automatic restart();
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        n_wr = 0;
        n_y = 0;
        n_a = 0;
        n_fl = 0;
    endtask : restart
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
    initial begin
        restart();
        for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check(32'(re), 32'h1);
        apb(1'b0, `RSC_OFF_STOP1, 32'h0);
        apb(1'b1, `RSC_OFF_STOP1, 32'h0001_0000);
        apb(1'b1, `RSC_OFF_THRLD, 32'h800);
        apb(1'b1, `RSC_OFF_PIE, 32'h3);
        apb(1'b1, `RSC_OFF_CTL, 32'h9D);
        settle();
        check(32'(pack), 32'h2);
        u_rsc_src_model.send(2, 1'b1, 1'b0);
        rd(`RSC_OFF_STAT, 32'h0);
        gen <= 1'b1;
        u_rsc_src_model.send(6, 1'b1, 1'b0);
        rd(`RSC_OFF_STAT, 32'h5);
        u_rsc_src_model.send(4091, 1'b1, 1'b0);
        settle();
        check(32'(n_wr), 32'd4096);
        check(32'(n_y), 32'd2);
        check(32'(last_d), 32'(u_rsc_src_model.seq - 20'h1));
        rd(`RSC_OFF_STAT, 32'h4000_0000);
        rd(`RSC_OFF_PIS, 32'h1);
        check(32'(irq), 32'h1);
        apb(1'b1, `RSC_OFF_STAT, 32'h0);
        rd(`RSC_OFF_STAT, 32'h4000_0000);
        apb(1'b1, `RSC_OFF_STAT, 32'h4000_0000);
        rd(`RSC_OFF_STAT, 32'h0);
        apb(1'b1, `RSC_OFF_PIS, 32'h1);
        full <= 1'b1;
        u_rsc_src_model.send(3, 1'b1, 1'b0);
        settle();
        full <= 1'b0;
        rd(`RSC_OFF_PIS, 32'h2);
        check(32'(irq), 32'h1);
        apb(1'b0, `RSC_OFF_STAT, 32'h0);
        c0 = rv;
        apb(1'b1, `RSC_OFF_CTL, 32'h29D);
        settle();
        check(32'(n_fl), 32'h1);
        u_rsc_src_model.send(4, 1'b1, 1'b0);
        settle();
        apb(1'b0, `RSC_OFF_STAT, 32'h0);
        check(rv - c0, 32'h4);
        check(32'(n_wr), 32'd4096);
        restart();
        apb(1'b1, `RSC_OFF_PORTCTL, 32'h1);
        apb(1'b1, `RSC_OFF_STRMCTL, 32'h1);
        settle();
        check(32'(fmt), 32'h1);
        apb(1'b1, `RSC_OFF_STOP1, 32'h8);
        apb(1'b1, `RSC_OFF_THRLD, 32'h8);
        apb(1'b1, `RSC_OFF_CTL, 32'h15);
        u_rsc_src_model.send(3, 1'b1, 1'b0);
        settle();
        check(32'(n_wr), 32'h0);
        u_rsc_src_model.send(9, 1'b1, 1'b1);
        settle();
        check(32'(n_wr), 32'h8);
        check(32'(n_a), 32'h1);
        rd(`RSC_OFF_STAT, 32'h4000_0000);
        apb(1'b1, `RSC_OFF_CTL, 32'h215);
        apb(1'b1, `RSC_OFF_CTL, 32'h15);
        u_rsc_src_model.send(9, 1'b1, 1'b1);
        settle();
        check(32'(n_wr), 32'h10);
        apb(1'b1, `RSC_OFF_CTL, 32'h5);
        u_rsc_src_model.send(9, 1'b1, 1'b1);
        u_rsc_src_model.send(9, 1'b1, 1'b1);
        settle();
        check(32'(n_wr), 32'h18);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire

/* File: hdl/rsc_capture.sv */
// Raw and stream capture channel with its APB register file.
// Assumes a capture FIFO outside that reports full on this clock and is
// drained by DMA; the capture pins come from another clock domain.
//
// Added by the designer: the register offsets and register access over APB.
`default_nettype none
`include "rsc_defines.svh"

module rsc_capture
    import rsc_pkg::*;
#(
    parameter int DATA_W = `RSC_DATA_W,
    parameter int CNT_W  = `RSC_CNT_W
) (
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              rst,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Capture pins from the external source.
    input  wire logic              channel_input_clock,
    input  wire logic              capture_qualifier,
    input  wire logic              packet_start_strobe,
    input  wire logic              packet_error,
    input  wire logic [DATA_W-1:0] capture_data,
    input  wire logic              global_capture_enable,
    // Capture FIFO write side.
    input  wire logic              fifo_full,
    output logic                   fifo_wr_valid,
    output logic      [DATA_W-1:0] fifo_wr_data,
    output logic                   fifo_flush,
    // DMA events, interrupt and mode outputs.
    output logic                   luma_dma_event,
    output logic                   channel_a_video_event,
    output logic                   irq,
    output logic      [1:0]        ten_bit_packing,
    output logic                   stream_input_format
);

    ////////////////////////////////////////////////////////////////////////
    // Register file state.

    logic [`RSC_CTL_W-1:0] channel_control_reg;
    logic [11:0]           hstop_reg;
    logic [11:0]           vstop_reg;
    logic [CNT_W-1:0]      threshold_reg;
    logic                  stream_select_reg;
    logic                  stream_format_reg;
    logic                  error_filter_reg;
    logic [1:0]            pie_reg;
    logic [1:0]            pis_reg;
    logic                  frame_complete_flag_reg;
    logic [31:0]           prdata_reg;
    logic                  pready_reg;
    logic                  pslverr_reg;

    logic [7:0] addr;
    logic       wr_acc;
    logic       setup;
    logic       channel_enable_bit;
    logic [2:0] capture_mode_field;
    logic       continuous_select;
    logic       single_frame;
    logic       raw_sync_enable;
    logic       block_capture_bit;
    logic       raw_mode;
    logic       stream_mode;

    assign addr   = paddr[7:0];
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite && pready_reg;

    assign channel_enable_bit = channel_control_reg[`RSC_CTL_EN];
    assign capture_mode_field =
        channel_control_reg[`RSC_CTL_MODE_HI:`RSC_CTL_MODE_LO];
    assign continuous_select  = channel_control_reg[`RSC_CTL_CON];
    assign single_frame       = channel_control_reg[`RSC_CTL_FRAME];
    assign raw_sync_enable    = channel_control_reg[`RSC_CTL_RSYNC];
    assign block_capture_bit  = channel_control_reg[`RSC_CTL_BLK];

    assign stream_mode = stream_select_reg &&
                         capture_mode_field == `RSC_MODE_STREAM;
    assign raw_mode    = capture_mode_field[1] && !stream_mode;

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for the capture pins.

    logic             clk_s1, clk_s2, clk_s3;
    logic             qual_s1, qual_s2;
    logic             pst_s1, pst_s2;
    logic             err_s1, err_s2;
    logic             gen_s1, gen_s2;
    logic [DATA_W-1:0] data_s1, data_s2;
    logic             edge_hit;

    always_ff @(posedge clk) begin
        if (rst) begin
            clk_s1  <= 1'b0;
            clk_s2  <= 1'b0;
            clk_s3  <= 1'b0;
            qual_s1 <= 1'b0;
            qual_s2 <= 1'b0;
            pst_s1  <= 1'b0;
            pst_s2  <= 1'b0;
            err_s1  <= 1'b0;
            err_s2  <= 1'b0;
            gen_s1  <= 1'b0;
            gen_s2  <= 1'b0;
            data_s1 <= '0;
            data_s2 <= '0;
        end else begin
            clk_s1  <= channel_input_clock;
            clk_s2  <= clk_s1;
            clk_s3  <= clk_s2;
            qual_s1 <= capture_qualifier;
            qual_s2 <= qual_s1;
            pst_s1  <= packet_start_strobe;
            pst_s2  <= pst_s1;
            err_s1  <= packet_error;
            err_s2  <= err_s1;
            gen_s1  <= global_capture_enable;
            gen_s2  <= gen_s1;
            data_s1 <= capture_data;
            data_s2 <= data_s1;
        end
    end

    assign edge_hit = clk_s2 && !clk_s3;

    ////////////////////////////////////////////////////////////////////////
    // Capture sequencing.

    rsc_state_e       state_reg;
    rsc_state_e       state_next;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] thr_cnt_reg;
    logic [CNT_W-1:0] block_size;
    logic             sync_seen_reg;
    logic             gate_reg;
    logic             unblock_arm_reg;
    logic             unblock_sync_reg;
    logic             drop_pkt_reg;
    logic             start_ok;
    logic             sample;
    logic             last_sample;
    logic             thr_hit;
    logic             discard;
    logic             frame_complete_flag_clear;
    logic             ovr_set;
    logic             blk_set_pulse;

    assign block_size  = {vstop_reg, hstop_reg};
    assign sample      = edge_hit && qual_s2 && state_reg == RSC_CAPT;
    assign last_sample = sample && count_reg + 1'b1 == block_size;
    assign thr_hit     = sample && threshold_reg != '0 &&
                         thr_cnt_reg + 1'b1 == threshold_reg;
    assign discard     = gate_reg || drop_pkt_reg;
    assign ovr_set     = sample && !discard && fifo_full;
    assign frame_complete_flag_clear  = wr_acc && addr == `RSC_OFF_STAT &&
                         pwdata[`RSC_STAT_FRAME_COMPLETE_FLAG];
    assign blk_set_pulse = wr_acc && addr == `RSC_OFF_CTL &&
                           pwdata[`RSC_CTL_BLK] && !block_capture_bit;

    always_comb begin
        start_ok = 1'b0;
        if (channel_enable_bit && edge_hit && qual_s2) begin
            if (stream_mode) begin
                start_ok = pst_s2;
            end else if (raw_mode) begin
                start_ok = gen_s2 &&
                           (sync_seen_reg || !raw_sync_enable);
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            RSC_IDLE: begin
                if (channel_enable_bit) begin
                    state_next = RSC_WAIT;
                end
            end
            RSC_WAIT: begin
                if (start_ok) begin
                    state_next = RSC_CAPT;
                end
            end
            RSC_CAPT: begin
                if (last_sample) begin
                    if (continuous_select) begin
                        state_next = RSC_WAIT;
                    end else if (single_frame || frame_complete_flag_reg) begin
                        state_next = RSC_STOP;
                    end else begin
                        state_next = RSC_WAIT;
                    end
                end
            end
            RSC_STOP: begin
                if (!frame_complete_flag_reg) begin
                    state_next = RSC_WAIT;
                end
            end
            default: state_next = RSC_IDLE;
        endcase
        if (!channel_enable_bit) begin
            state_next = RSC_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= RSC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Sample counters; the data counter runs even while blocked.
    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg   <= '0;
            thr_cnt_reg <= '0;
        end else if (state_reg == RSC_WAIT && start_ok) begin
            count_reg   <= '0;
            thr_cnt_reg <= '0;
        end else if (sample) begin
            count_reg   <= last_sample ? '0 : count_reg + 1'b1;
            thr_cnt_reg <= thr_hit ? '0 : thr_cnt_reg + 1'b1;
        end
    end

    // Raw sync: a qualifier-inactive edge marks a sync period.
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_seen_reg <= 1'b0;
        end else if (state_reg == RSC_STOP || state_reg == RSC_IDLE) begin
            sync_seen_reg <= 1'b0;
        end else if (edge_hit && !qual_s2) begin
            sync_seen_reg <= 1'b1;
        end
    end

    // Block capture gate and its delayed release.
    always_ff @(posedge clk) begin
        if (rst) begin
            gate_reg         <= 1'b0;
            unblock_arm_reg  <= 1'b0;
            unblock_sync_reg <= 1'b0;
        end else if (block_capture_bit) begin
            gate_reg         <= 1'b1;
            unblock_arm_reg  <= 1'b1;
            unblock_sync_reg <= 1'b0;
        end else if (gate_reg && unblock_arm_reg) begin
            if (stream_mode) begin
                if (edge_hit && qual_s2 && pst_s2) begin
                    gate_reg        <= 1'b0;
                    unblock_arm_reg <= 1'b0;
                end
            end else if (!unblock_sync_reg) begin
                if (edge_hit && !qual_s2) begin
                    unblock_sync_reg <= 1'b1;
                end
            end else if (last_sample ||
                         (state_reg == RSC_WAIT && start_ok)) begin
                gate_reg         <= 1'b0;
                unblock_arm_reg  <= 1'b0;
                unblock_sync_reg <= 1'b0;
            end
        end
    end

    // Error packet filter drops a packet flagged at its start.
    always_ff @(posedge clk) begin
        if (rst) begin
            drop_pkt_reg <= 1'b0;
        end else if (stream_mode && edge_hit && qual_s2 && pst_s2 &&
                     (state_reg == RSC_WAIT || last_sample)) begin
            drop_pkt_reg <= error_filter_reg && err_s2;
        end else if (!stream_mode) begin
            drop_pkt_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // FIFO write side and DMA events.

    always_ff @(posedge clk) begin
        if (rst) begin
            fifo_wr_valid <= 1'b0;
            fifo_wr_data  <= '0;
            fifo_flush    <= 1'b0;
        end else begin
            fifo_wr_valid <= sample && !discard && !fifo_full;
            fifo_wr_data  <= data_s2;
            fifo_flush    <= blk_set_pulse;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            luma_dma_event        <= 1'b0;
            channel_a_video_event <= 1'b0;
        end else begin
            luma_dma_event        <= thr_hit && !discard &&
                                     raw_mode;
            channel_a_video_event <= thr_hit && !discard &&
                                     stream_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags; a set in the same cycle as a clear wins.

    always_ff @(posedge clk) begin
        if (rst) begin
            frame_complete_flag_reg <= 1'b0;
        end else if (last_sample) begin
            frame_complete_flag_reg <= 1'b1;
        end else if (frame_complete_flag_clear) begin
            frame_complete_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pis_reg <= 2'h0;
        end else begin
            if (last_sample) begin
                pis_reg[`RSC_PIS_CCMP] <= 1'b1;
            end else if (wr_acc && addr == `RSC_OFF_PIS &&
                         pwdata[`RSC_PIS_CCMP]) begin
                pis_reg[`RSC_PIS_CCMP] <= 1'b0;
            end
            if (ovr_set) begin
                pis_reg[`RSC_PIS_COVR] <= 1'b1;
            end else if (wr_acc && addr == `RSC_OFF_PIS &&
                         pwdata[`RSC_PIS_COVR]) begin
                pis_reg[`RSC_PIS_COVR] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(pis_reg & pie_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes.

    always_ff @(posedge clk) begin
        if (rst) begin
            channel_control_reg <= '0;
            hstop_reg           <= 12'h000;
            vstop_reg           <= 12'h000;
            threshold_reg       <= '0;
            stream_select_reg   <= 1'b0;
            stream_format_reg   <= 1'b0;
            error_filter_reg    <= 1'b0;
            pie_reg             <= 2'h0;
        end else if (wr_acc) begin
            if (addr == `RSC_OFF_CTL) begin
                channel_control_reg <= pwdata[`RSC_CTL_W-1:0];
            end else if (addr == `RSC_OFF_STOP1) begin
                hstop_reg <= pwdata[11:0];
                vstop_reg <= pwdata[`RSC_STOP_V_HI:`RSC_STOP_V_LO];
            end else if (addr == `RSC_OFF_THRLD) begin
                threshold_reg <= pwdata[CNT_W-1:0];
            end else if (addr == `RSC_OFF_PORTCTL) begin
                stream_select_reg <= pwdata[0];
            end else if (addr == `RSC_OFF_STRMCTL) begin
                stream_format_reg <= pwdata[0];
                error_filter_reg  <= pwdata[1];
            end else if (addr == `RSC_OFF_PIE) begin
                pie_reg <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ten_bit_packing     <= 2'h0;
            stream_input_format <= 1'b0;
        end else begin
            ten_bit_packing     <=
                channel_control_reg[`RSC_CTL_PK_HI:`RSC_CTL_PK_LO];
            stream_input_format <= stream_format_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB read path: data is latched in the setup cycle.

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            if (addr[1:0] != 2'h0) begin
                pslverr_reg <= 1'b1;
            end else if (addr == `RSC_OFF_CTL) begin
                prdata_reg[`RSC_CTL_W-1:0] <= channel_control_reg;
            end else if (addr == `RSC_OFF_STAT) begin
                prdata_reg[CNT_W-1:0]         <= count_reg;
                prdata_reg[`RSC_STAT_FRAME_COMPLETE_FLAG]    <= frame_complete_flag_reg;
            end else if (addr == `RSC_OFF_STOP1) begin
                prdata_reg[11:0] <= hstop_reg;
                prdata_reg[`RSC_STOP_V_HI:`RSC_STOP_V_LO] <= vstop_reg;
            end else if (addr == `RSC_OFF_THRLD) begin
                prdata_reg[CNT_W-1:0] <= threshold_reg;
            end else if (addr == `RSC_OFF_PORTCTL) begin
                prdata_reg[0] <= stream_select_reg;
            end else if (addr == `RSC_OFF_STRMCTL) begin
                prdata_reg[1:0] <= {error_filter_reg, stream_format_reg};
            end else if (addr == `RSC_OFF_PIE) begin
                prdata_reg[1:0] <= pie_reg;
            end else if (addr == `RSC_OFF_PIS) begin
                prdata_reg[1:0] <= pis_reg;
            end else begin
                pslverr_reg <= 1'b1;
            end
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

endmodule : rsc_capture

`default_nettype wire

/* File: hdl/rsc_defines.svh */
// Register offsets, field positions and widths of the capture channel.
// Assumes a 32-bit APB slave with byte addresses on paddr.
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

`define RSC_ADDR_W        8
`define RSC_OFF_CTL       8'h00
`define RSC_OFF_STAT      8'h04
`define RSC_OFF_STOP1     8'h08
`define RSC_OFF_THRLD     8'h0C
`define RSC_OFF_PORTCTL   8'h10
`define RSC_OFF_STRMCTL   8'h14
`define RSC_OFF_PIE       8'h18
`define RSC_OFF_PIS       8'h1C

`define RSC_CTL_EN        0
`define RSC_CTL_MODE_LO   1
`define RSC_CTL_MODE_HI   3
`define RSC_CTL_CON       4
`define RSC_CTL_FRAME     5
`define RSC_CTL_PK_LO     6
`define RSC_CTL_PK_HI     7
`define RSC_CTL_RSYNC     8
`define RSC_CTL_BLK       9
`define RSC_CTL_W         10

`define RSC_STAT_FRAME_COMPLETE_FLAG     30
`define RSC_STOP_V_LO     16
`define RSC_STOP_V_HI     27
`define RSC_PIS_CCMP      0
`define RSC_PIS_COVR      1
`define RSC_MODE_STREAM   3'h2
`define RSC_DATA_W        20
`define RSC_CNT_W         24

`endif

/* File: hdl/rsc_pkg.sv */
// Types shared by the capture channel.
// Assumes nothing beyond the defines header.
`default_nettype none

package rsc_pkg;
    typedef enum logic [1:0] {
        RSC_IDLE = 2'b00,
        RSC_WAIT = 2'b01,
        RSC_CAPT = 2'b10,
        RSC_STOP = 2'b11
    } rsc_state_e;
endpackage : rsc_pkg

`default_nettype wire
